// ---- dv/fp_dispatch_model.sv ----
// Dispatch and integer pipeline model feeding both issue slots
`timescale 1ns/1ps
module fp_dispatch_model (
  input wire logic i_clk,
  input wire logic i_a_issue,
  input wire logic i_b_issue,
  output logic [19:0] o_a,
  output logic [19:0] o_b,
  output logic o_hold
);
  // Slot word: valid, unit, dbl, src1, src2, dst, trap_risk
  initial begin
    o_a = 20'h0_0000;
    o_b = 20'h0_0000;
    o_hold = 1'b0;
  end
  // Requests change at the falling edge and stand until taken
  task automatic send(input logic [19:0] x, input logic [19:0] y, input int h, output int n);
    logic ta;
    logic tb;
    n = 0;
    @(negedge i_clk);
    o_a = x;
    o_b = y;
    o_hold = (h > 0);
    while (o_a[19] && n < 300) begin
      #1;
      ta = i_a_issue;
      tb = i_b_issue;
      @(negedge i_clk);
      n++;
      o_hold = (n < h);
      if (ta && !tb)
        o_a = o_b; // Younger op slides into the older slot
      else if (ta)
        o_a = {1'b0, ~o_a[18:0]}; // Stale fields flip so they are never trusted
      if (ta)
        o_b = {1'b0, ~o_b[18:0]};
    end
  endtask : send
endmodule : fp_dispatch_model

// ---- dv/test_fp_issue_pipeline_control.sv ----
// Self-checking bench for the floating-point issue control
`timescale 1ns/1ps
module test_fp_issue_pipeline_control;
  import fp_issue_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [19:0] a;
  logic [19:0] b;
  logic hold, ai, bi, trap, busy, wbv, wbd, dd, ddbl;
  logic [4:0] wbr;
  logic [4:0] dr;
  logic [1:0] wbu;
  logic [31:0] pend;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  always #4 i_clk = ~i_clk;
  fp_dispatch_model fp_dispatch_model_i (.i_clk(i_clk), .i_a_issue(ai), .i_b_issue(bi), .o_a(a), .o_b(b),
    .o_hold(hold));
  fp_issue_pipeline_control fp_issue_pipeline_control_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_a_valid(a[19]), .i_a_unit(fp_unit_t'(a[18:17])), .i_a_dbl(a[16]), .i_a_src1(a[15:11]),
    .i_a_src2(a[10:6]), .i_a_dst(a[5:1]), .i_a_trap_risk(a[0]), .i_b_valid(b[19]),
    .i_b_unit(fp_unit_t'(b[18:17])), .i_b_dbl(b[16]), .i_b_src1(b[15:11]), .i_b_src2(b[10:6]),
    .i_b_dst(b[5:1]), .i_b_trap_risk(b[0]), .i_int_hold(hold), .o_a_issue(ai), .o_b_issue(bi),
    .o_trap_predict(trap), .o_div_busy(busy), .o_wb_valid(wbv), .o_wb_reg(wbr), .o_wb_dbl(wbd),
    .o_wb_unit(wbu), .o_div_done(dd), .o_div_reg(dr), .o_div_dbl(ddbl), .o_pending(pend));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  function automatic logic [19:0] op(fp_unit_t u, logic d, logic [4:0] s, logic [4:0] t, logic r);
    return {1'b1, u, d, s, s ^ 5'h01, t, r};
  endfunction : op
  // Hands a pair to the model; a slot never taken ends the run
  task automatic go(input logic [19:0] x, input logic [19:0] y, input int h, output int k);
    fp_dispatch_model_i.send(x, y, h, k);
    if (k >= 300) begin
      check("issue_timeout", 1'b1, 1'b0);
      conclude();
    end
  endtask : go
  // Falling edges from the call to a completion pulse, then the pulse must drop
  task automatic wait_done(input logic sel, output int k);
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while ((sel ? dd : wbv) !== 1'b1 && k < 300);
    if (k >= 300) begin
      check("done_timeout", 1'b1, 1'b0);
      conclude();
    end
    @(negedge i_clk);
    check("pulse_len", sel ? dd : wbv, 1'b0);
  endtask : wait_done
  task automatic t_pipe();
    for (int i = 0; i < 4; i++) begin
      go(op(fp_unit_t'(i % 2), i[1], 5'h10, 5'h01, 1'b0), '0, 0, n);
      check("pend_set", {n[3:0], pend[1]}, 5'h03);
      wait_done(1'b0, n);
      check("wb_lat", n, 3);
      check("wb_out", {pend[1], wbu, wbd, wbr}, {1'b0, 2'(i % 2), i[1], 5'h01});
    end
  endtask : t_pipe
  task automatic t_dual();
    go(op(UNIT_ADD, 1'b0, 5'h10, 5'h02, 1'b0), op(UNIT_MUL, 1'b1, 5'h14, 5'h03, 1'b0), 0, n);
    check("dual_issue", {n[3:0], pend[3:2]}, 6'h07);
    wait_done(1'b0, n);
    check("dual_clear", pend[3:2], 2'h0);
  endtask : t_dual
  task automatic t_div(input logic d, input int lat);
    go(op(UNIT_DIV, d, 5'h14, 5'h04, 1'b1), '0, 0, n);
    check("trap_busy", {trap, busy}, 2'h3);
    @(negedge i_clk);
    go(op(UNIT_ADD, d, 5'h16, 5'h06, 1'b0), '0, 0, n);
    check("no_stall", n, 1);
    wait_done(1'b0, n);
    check("early_wb", {wbr, pend[4]}, {5'h06, 1'b1});
    wait_done(1'b1, n);
    check("div_lat", n, lat - 7);
    check("div_out", {ddbl, dr, pend[4], busy}, {d, 5'h04, 2'h0});
  endtask : t_div
  task automatic t_hazard();
    go(op(UNIT_DIV, 1'b0, 5'h18, 5'h0A, 1'b0), '0, 0, n);
    go(op(UNIT_DIV, 1'b0, 5'h18, 5'h0B, 1'b0), '0, 0, n);
    check("div_wait", {n > 10, trap}, 2'h2);
    go(op(UNIT_ADD, 1'b0, 5'h1C, 5'h0C, 1'b0), '0, 0, n);
    go(op(UNIT_MUL, 1'b0, 5'h0C, 5'h0D, 1'b0), '0, 0, n);
    check("raw_hold", n, 3);
    go(op(UNIT_ADD, 1'b0, 5'h1C, 5'h0E, 1'b0), '0, 2, n);
    check("int_hold", n, 3);
    wait_done(1'b1, n);
  endtask : t_hazard
  // Reset, then every scenario in turn
  initial begin
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    check("reset_pend", pend, 32'h0000_0000);
    t_pipe();
    t_dual();
    t_div(1'b0, 12);
    t_div(1'b1, 22);
    t_hazard();
    conclude();
  end
endmodule : test_fp_issue_pipeline_control

// ---- hw/fp_issue_params.svh ----
// Constants for the floating-point issue and completion control
// Operation
// RULE1: Separate add, multiply, divide/sqrt sub-units
// RULE2: Up to two operations issue per cycle
// RULE3: Thirty-two register entries, single or double
// RULE4: Pipelined ops accept each cycle, latency three
// RULE5: Pipelined latency independent of precision
// RULE6: Divide/sqrt: 12 single, 22 double cycles
// RULE7: Long divide does not stall later instructions
// RULE8: Stay in step, predict long traps
// RULE9: One divide/sqrt in flight at once
// RULE10: Hold readers of pending results
`ifndef FP_ISSUE_PARAMS_SVH
`define FP_ISSUE_PARAMS_SVH
`define FP_REGS 32
`define FP_PIPE_LAT 3
`define FP_DIV_SP_LAT 12
`define FP_DIV_DP_LAT 22
`endif

// ---- hw/fp_issue_pipeline_control.sv ----
// Issue, scoreboard and completion control for the floating-point unit
`timescale 1ns/1ps
`include "fp_issue_params.svh"
module fp_issue_pipeline_control #(
  parameter int unsigned REGS = `FP_REGS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_a_valid,
  input wire fp_issue_pkg::fp_unit_t i_a_unit,
  input wire logic i_a_dbl,
  input wire logic [4:0] i_a_src1,
  input wire logic [4:0] i_a_src2,
  input wire logic [4:0] i_a_dst,
  input wire logic i_a_trap_risk,
  input wire logic i_b_valid,
  input wire fp_issue_pkg::fp_unit_t i_b_unit,
  input wire logic i_b_dbl,
  input wire logic [4:0] i_b_src1,
  input wire logic [4:0] i_b_src2,
  input wire logic [4:0] i_b_dst,
  input wire logic i_b_trap_risk,
  input wire logic i_int_hold,
  output logic o_a_issue,
  output logic o_b_issue,
  output logic o_trap_predict,
  output logic o_div_busy,
  output logic o_wb_valid,
  output logic [4:0] o_wb_reg,
  output logic o_wb_dbl,
  output logic [1:0] o_wb_unit,
  output logic o_div_done,
  output logic [4:0] o_div_reg,
  output logic o_div_dbl,
  output logic [REGS-1:0] o_pending
);
  import fp_issue_pkg::*;

  localparam logic [4:0] SP_CNT = 5'(`FP_DIV_SP_LAT - 1);
  localparam logic [4:0] DP_CNT = 5'(`FP_DIV_DP_LAT - 1);

  typedef struct packed {
    logic [`FP_PIPE_LAT-1:0] add_v;
    logic [`FP_PIPE_LAT-1:0][5:0] add_d;
    logic [`FP_PIPE_LAT-1:0] mul_v;
    logic [`FP_PIPE_LAT-1:0][5:0] mul_d;
    logic div_busy;
    logic [4:0] div_cnt;
    logic [5:0] div_d;
    logic [REGS-1:0] pend;
    logic wb_valid;
    logic [4:0] wb_reg;
    logic wb_dbl;
    logic [1:0] wb_unit;
    logic div_done;
    logic [4:0] div_reg;
    logic div_dbl;
    logic trap_pred;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Any operand or the destination still has a result outstanding (read and write hazards)
  function automatic logic blocked(input logic [REGS-1:0] p, input logic [4:0] s1, input logic [4:0] s2,
                                   input logic [4:0] d);
    blocked = p[s1] | p[s2] | p[d];
  endfunction : blocked

  logic a_go;
  logic b_go;

  // Issue decision: each slot needs a free sub-unit and clean operands
  always_comb begin
    a_go = i_a_valid && !i_int_hold && (i_a_unit != UNIT_NONE) // RULE8
        && !blocked(st_r.pend, i_a_src1, i_a_src2, i_a_dst) // RULE10
        && !(i_a_unit == UNIT_DIV && st_r.div_busy); // RULE9
    b_go = i_b_valid && !i_int_hold && (i_b_unit != UNIT_NONE) && a_go // Keeps program order
        && (i_b_unit != i_a_unit) // RULE1 RULE2
        && !blocked(st_r.pend, i_b_src1, i_b_src2, i_b_dst) // RULE10
        && i_b_src1 != i_a_dst && i_b_src2 != i_a_dst && i_b_dst != i_a_dst
        && !(i_b_unit == UNIT_DIV && st_r.div_busy); // RULE9
  end

  // Next state: shift pipes, count divide, update scoreboard
  always_comb begin
    st_nxt = st_r;
    st_nxt.wb_valid = 1'b0;
    st_nxt.div_done = 1'b0;
    st_nxt.trap_pred = 1'b0;
    // Fixed three-stage pipes, no precision dependence
    for (int i = `FP_PIPE_LAT - 1; i > 0; i--) begin
      st_nxt.add_v[i] = st_r.add_v[i-1]; // RULE4 RULE5
      st_nxt.add_d[i] = st_r.add_d[i-1];
      st_nxt.mul_v[i] = st_r.mul_v[i-1];
      st_nxt.mul_d[i] = st_r.mul_d[i-1];
    end
    st_nxt.add_v[0] = 1'b0;
    st_nxt.mul_v[0] = 1'b0;
    // Add and multiply can retire in the same cycle; both clear their pending bits,
    // but the adder has priority on the single pipelined write port stage
    if (st_r.add_v[`FP_PIPE_LAT-1]) begin
      st_nxt.wb_valid = 1'b1;
      st_nxt.wb_reg = st_r.add_d[`FP_PIPE_LAT-1][4:0];
      st_nxt.wb_dbl = st_r.add_d[`FP_PIPE_LAT-1][5];
      st_nxt.wb_unit = UNIT_ADD;
      st_nxt.pend[st_r.add_d[`FP_PIPE_LAT-1][4:0]] = 1'b0;
    end
    if (st_r.mul_v[`FP_PIPE_LAT-1]) begin
      st_nxt.pend[st_r.mul_d[`FP_PIPE_LAT-1][4:0]] = 1'b0;
      if (!st_r.add_v[`FP_PIPE_LAT-1]) begin
        st_nxt.wb_valid = 1'b1;
        st_nxt.wb_reg = st_r.mul_d[`FP_PIPE_LAT-1][4:0];
        st_nxt.wb_dbl = st_r.mul_d[`FP_PIPE_LAT-1][5];
        st_nxt.wb_unit = UNIT_MUL;
      end
    end
    // Divide runs beside the pipes and retires on its own port
    if (st_r.div_busy) begin
      if (st_r.div_cnt == 5'h00) begin
        st_nxt.div_busy = 1'b0; // RULE6
        st_nxt.div_done = 1'b1;
        st_nxt.div_reg = st_r.div_d[4:0];
        st_nxt.div_dbl = st_r.div_d[5];
        st_nxt.pend[st_r.div_d[4:0]] = 1'b0;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt - 5'h01;
      end
    end
    // Launch new operations into their sub-units
    if (a_go) begin
      unique case (i_a_unit)
        UNIT_ADD: begin
          st_nxt.add_v[0] = 1'b1;
          st_nxt.add_d[0] = {i_a_dbl, i_a_dst};
        end
        UNIT_MUL: begin
          st_nxt.mul_v[0] = 1'b1;
          st_nxt.mul_d[0] = {i_a_dbl, i_a_dst};
        end
        UNIT_DIV: begin
          st_nxt.div_busy = 1'b1;
          st_nxt.div_cnt = i_a_dbl ? DP_CNT : SP_CNT; // RULE6
          st_nxt.div_d = {i_a_dbl, i_a_dst};
        end
        default: ;
      endcase
      st_nxt.pend[i_a_dst] = 1'b1; // RULE3
      st_nxt.trap_pred = i_a_trap_risk && i_a_unit == UNIT_DIV; // RULE8
    end
    if (b_go) begin
      unique case (i_b_unit)
        UNIT_ADD: begin
          st_nxt.add_v[0] = 1'b1;
          st_nxt.add_d[0] = {i_b_dbl, i_b_dst};
        end
        UNIT_MUL: begin
          st_nxt.mul_v[0] = 1'b1;
          st_nxt.mul_d[0] = {i_b_dbl, i_b_dst};
        end
        UNIT_DIV: begin
          st_nxt.div_busy = 1'b1;
          st_nxt.div_cnt = i_b_dbl ? DP_CNT : SP_CNT;
          st_nxt.div_d = {i_b_dbl, i_b_dst};
        end
        default: ;
      endcase
      st_nxt.pend[i_b_dst] = 1'b1;
      st_nxt.trap_pred = st_nxt.trap_pred | (i_b_trap_risk && i_b_unit == UNIT_DIV);
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_a_issue = a_go;
  assign o_b_issue = b_go;
  assign o_trap_predict = st_r.trap_pred;
  assign o_div_busy = st_r.div_busy; // RULE7
  assign o_wb_valid = st_r.wb_valid;
  assign o_wb_reg = st_r.wb_reg;
  assign o_wb_dbl = st_r.wb_dbl;
  assign o_wb_unit = st_r.wb_unit;
  assign o_div_done = st_r.div_done;
  assign o_div_reg = st_r.div_reg;
  assign o_div_dbl = st_r.div_dbl;
  assign o_pending = st_r.pend;

  // Pipelined add result appears three cycles after issue
  sequence add_issue_s;
    o_a_issue && i_a_unit == UNIT_ADD;
  endsequence
  // Double divide stays quiet early on, then retires on the last count
  sequence div_dbl_run_s;
    !o_div_done [*8] ##15 o_div_done;
  endsequence
  // Registered pulses show after the edge that ends the count, hence the extra cycle
  chk_add_latency: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE4
    add_issue_s |=> ##(`FP_PIPE_LAT) (o_wb_valid && o_wb_unit == UNIT_ADD))
    else $error("add result not on time");
  // A same-cycle add would own the write port, so that pairing is left out
  chk_mul_latency: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    (o_a_issue && i_a_unit == UNIT_MUL && i_a_dbl && !(o_b_issue && i_b_unit == UNIT_ADD))
    |=> ##(`FP_PIPE_LAT) (o_wb_valid && o_wb_unit == UNIT_MUL && o_wb_dbl))
    else $error("double multiply latency differs");
  chk_div_single: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    (o_a_issue && i_a_unit == UNIT_DIV && !i_a_dbl) |=> ##12 o_div_done)
    else $error("single divide not done in 12");
  chk_div_double: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    (o_a_issue && i_a_unit == UNIT_DIV && i_a_dbl) |=> div_dbl_run_s)
    else $error("double divide not done in 22");
  chk_div_single_use: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    o_div_busy |-> !(o_a_issue && i_a_unit == UNIT_DIV) && !(o_b_issue && i_b_unit == UNIT_DIV))
    else $error("second divide while busy");
  chk_div_nostall: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
    (o_div_busy && i_a_valid && i_a_unit == UNIT_ADD && !i_int_hold
     && !blocked(o_pending, i_a_src1, i_a_src2, i_a_dst)) |-> o_a_issue)
    else $error("divide stalled an add");
  chk_raw_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE10
    (i_a_valid && o_pending[i_a_src1]) |-> !o_a_issue)
    else $error("read of pending register issued");
  chk_dual_units: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
    (o_a_issue && o_b_issue) |-> i_a_unit != i_b_unit)
    else $error("two ops on one sub-unit");
  chk_int_sync: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE8
    i_int_hold |-> !o_a_issue && !o_b_issue)
    else $error("issue while integer pipe holds");
  chk_trap_pred: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE8
    (o_a_issue && i_a_unit == UNIT_DIV && i_a_trap_risk) |=> o_trap_predict)
    else $error("trap not predicted");
endmodule : fp_issue_pipeline_control

// ---- hw/fp_issue_pkg.sv ----
// Types for the floating-point issue and completion control
package fp_issue_pkg;
  // Sub-unit selector for an issue slot
  typedef enum logic [1:0] {
    UNIT_ADD = 2'b00,
    UNIT_MUL = 2'b01,
    UNIT_DIV = 2'b10,
    UNIT_NONE = 2'b11
  } fp_unit_t;
endpackage : fp_issue_pkg
